// >>> hw/rsch_hex.sv
/*
 rsch_hex: nibble to ascii hex character and ascii hex character to nibble.
 Assumes: upper and lower case digits are accepted, upper case is produced.
*/
`timescale 1ns/1ns
module rsch_hex (
    input wire logic [3:0] nibble_in,
    output logic [7:0] char_out,
    input wire logic [7:0] char_in,
    output logic [3:0] nibble_out,
    output logic nibble_ok
);
    logic is_digit;
    logic is_upper;
    logic is_lower;

    assign char_out = (nibble_in < 4'ha) ? (8'h30 + {4'h0, nibble_in})
                                         : (8'h37 + {4'h0, nibble_in});
    assign is_digit = (char_in >= 8'h30) && (char_in <= 8'h39);
    assign is_upper = (char_in >= 8'h41) && (char_in <= 8'h46);
    assign is_lower = (char_in >= 8'h61) && (char_in <= 8'h66);
    assign nibble_ok = is_digit | is_upper | is_lower;
    assign nibble_out = is_digit ? char_in[3:0]
                      : (char_in[3:0] + 4'h9);
endmodule // rsch_hex

// >>> hw/rsch_pkg.sv
/*
 rsch_pkg: constants, opcodes, register offsets and state type of the
 remote status command handler.
 Assumes: shared by the handler top and its setup memory.
*/
package rsch_pkg;
    // avalon register window, byte addresses of aligned words
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam logic [5:0] OFF_CMD = 6'h00;
    localparam logic [5:0] OFF_RESP = 6'h04;
    localparam logic [5:0] OFF_LEARN = 6'h08;
    localparam logic [5:0] OFF_INSTALL = 6'h0c;
    localparam logic [5:0] OFF_IRQ_STATUS = 6'h10;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h14;
    localparam logic [5:0] OFF_SETUP_ADDR = 6'h18;
    localparam logic [5:0] OFF_SETUP_DATA = 6'h1c;
    localparam logic [5:0] OFF_STATUS = 6'h20;
    localparam logic [3:0] BE_ALL = 4'hf;

    // command word layout
    localparam int OP_LSB = 0;
    localparam int OP_W = 5;
    localparam int ARG_LSB = 8;
    localparam int ARG_W = 8;

    // command opcodes
    localparam logic [4:0] OP_CLEAR_STATUS = 5'h01;
    localparam logic [4:0] OP_EVENT_EN_SET = 5'h02;
    localparam logic [4:0] OP_EVENT_EN_Q = 5'h03;
    localparam logic [4:0] OP_EVENT_STAT_Q = 5'h04;
    localparam logic [4:0] OP_INDIV_STAT_Q = 5'h05;
    localparam logic [4:0] OP_OPER_COMPLETE = 5'h06;
    localparam logic [4:0] OP_OPER_COMPLETE_Q = 5'h07;
    localparam logic [4:0] OP_POLL_EN_SET = 5'h08;
    localparam logic [4:0] OP_POLL_EN_Q = 5'h09;
    localparam logic [4:0] OP_SRQ_EN_SET = 5'h0a;
    localparam logic [4:0] OP_SRQ_EN_Q = 5'h0b;
    localparam logic [4:0] OP_STATUS_BYTE_Q = 5'h0c;
    localparam logic [4:0] OP_WAIT = 5'h0d;
    localparam logic [4:0] OP_SETUP_SAVE = 5'h0e;
    localparam logic [4:0] OP_EXEC_ERR_Q = 5'h0f;
    localparam logic [4:0] OP_QUERY_ERR_Q = 5'h10;
    localparam logic [4:0] OP_LEARN_Q = 5'h11;
    localparam logic [4:0] OP_INSTALL = 5'h12;
    localparam logic [4:0] OP_LAST = 5'h12;

    // event status, status byte and interrupt bit positions
    localparam int ESR_OPC = 0;
    localparam int ESR_QYE = 2;
    localparam int ESR_EXE = 4;
    localparam int ESR_CME = 5;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int IRQ_W = 3;
    localparam int IRQ_RESP = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_ERR = 2;
    localparam int RESP_VALID_BIT = 8;
    localparam int STATUS_ESR_LSB = 8;

    // setup storage
    localparam int SETUP_BYTES = 421;
    localparam int LEARN_CHARS = 842;
    localparam int STORE_MIN = 1;
    localparam int STORE_MAX = 9;
    localparam int STORE_CNT = 10;
    localparam int MEM_AW = 13;
    localparam int MEM_DEPTH = STORE_CNT * SETUP_BYTES;
    localparam int SETUP_AW = 9;
    localparam int CHAR_W = 10;
    localparam logic [7:0] TERM_CHAR = 8'h0a;
    localparam logic [7:0] OPC_ANSWER = 8'h01;

    // error numbers
    localparam logic [7:0] EXE_ERR_STORE = 8'h01;
    localparam logic [7:0] EXE_ERR_BLOCK = 8'h02;
    localparam logic [7:0] QRY_ERR_UNREAD = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LWAIT = 4'b0010,
        ST_ACK = 4'b0100,
        ST_SAVE = 4'b1000
    } rsch_state_type;

    function automatic logic [MEM_AW-1:0] store_base(input logic [3:0] n);
        store_base = MEM_AW'(int'(n) * SETUP_BYTES);
    endfunction
endpackage

// >>> hw/rsch_setup_mem.sv
/*
 rsch_setup_mem: byte memory for the working setup and the nine stores,
 one write port, one registered read port.
 Assumes: a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module rsch_setup_mem (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [rsch_pkg::MEM_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [rsch_pkg::MEM_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [0:rsch_pkg::MEM_DEPTH-1];

    // array has no reset; contents are undefined until written through the setup window, installed or saved
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule // rsch_setup_mem

// >>> hw/rsch_top.sv
/*
 rsch_top: remote status command handler with avalon-mm register access,
 status reporting registers, setup save, learn and install.
 Assumes: avalon master on ref_clk; exe_err and ist_local come from logic
 on the same clock.
*/
// Functional notes
// - setup save targets only stores 1 to 9
// - learn returns setup as 842 hex characters then the terminator
// - learn only reads; no setting changes
// - install writes the hex block back into the working setup
// - execution error query reports the number and clears it
// - query error query reports the number and clears it
// - clear status zeroes event status and both error registers
// - event enable set loads the mask; its query returns it
// - event status query returns the register then clears it
// - individual status query answers 0 or 1 from ist
// - operation complete sets event status bit 0 at once
// - operation complete query always answers 1 at once
// - poll enable set stores argument; its query returns it
// - service request enable set stores argument; query returns it
// - status byte query returns the current status byte
// - each command completes before the next access is taken
// - wait command is accepted and only sets the done interrupt bit
`timescale 1ns/1ns
module rsch_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [rsch_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [rsch_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [rsch_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic exe_err_valid,
    input wire logic [7:0] exe_err_code,
    input wire logic ist_local,
    output logic irq,
    output logic srq,
    output logic [7:0] status_byte
);
    rsch_pkg::rsch_state_type state_q, state_d;
    logic [7:0] ese_q, esr_q, pre_q, sre_q, exe_q, qry_q, resp_q;
    logic [7:0] ese_d, esr_d, pre_d, sre_d, exe_d, qry_d, resp_d;
    logic resp_valid_q, resp_valid_d;
    logic [rsch_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
    logic [rsch_pkg::CHAR_W-1:0] learn_ptr_q, learn_ptr_d;
    logic [rsch_pkg::CHAR_W-1:0] inst_ptr_q, inst_ptr_d;
    logic [3:0] inst_hi_q;
    logic [rsch_pkg::SETUP_AW-1:0] setup_addr_q, save_cnt_q;
    logic [3:0] save_dst_q;
    logic [rsch_pkg::DATA_W-1:0] rdata_q, rdata_d, reg_rdata, mem_rdata;
    logic irq_q, srq_q;
    logic [7:0] stb_q;

    // access decode
    logic ack, be_full, req, mem_read;
    logic wr_acc, rd_acc;
    assign ack = (state_q == rsch_pkg::ST_ACK);
    assign be_full = (avs_byteenable == rsch_pkg::BE_ALL);
    assign req = avs_read | avs_write;
    assign mem_read = avs_read && ((avs_address == rsch_pkg::OFF_LEARN) ||
                      (avs_address == rsch_pkg::OFF_SETUP_DATA));
    assign wr_acc = ack && avs_write && be_full;
    assign rd_acc = ack && avs_read;

    // command decode
    logic cmd_go;
    logic [4:0] op;
    logic [7:0] arg;
    assign cmd_go = wr_acc && (avs_address == rsch_pkg::OFF_CMD);
    assign op = avs_writedata[rsch_pkg::OP_LSB +: rsch_pkg::OP_W];
    assign arg = avs_writedata[rsch_pkg::ARG_LSB +: rsch_pkg::ARG_W];

    logic do_cls, do_ese, do_opc, do_pre, do_sre, do_save, do_learn;
    logic do_inst, do_esr_q, do_exe_q, do_qry_q, cmd_err, is_query;
    logic store_ok, bad_store;
    assign do_cls = cmd_go && (op == rsch_pkg::OP_CLEAR_STATUS);
    assign do_ese = cmd_go && (op == rsch_pkg::OP_EVENT_EN_SET);
    assign do_opc = cmd_go && (op == rsch_pkg::OP_OPER_COMPLETE);
    assign do_pre = cmd_go && (op == rsch_pkg::OP_POLL_EN_SET);
    assign do_sre = cmd_go && (op == rsch_pkg::OP_SRQ_EN_SET);
    assign do_save = cmd_go && (op == rsch_pkg::OP_SETUP_SAVE);
    assign do_learn = cmd_go && (op == rsch_pkg::OP_LEARN_Q);
    assign do_inst = cmd_go && (op == rsch_pkg::OP_INSTALL);
    assign do_esr_q = cmd_go && (op == rsch_pkg::OP_EVENT_STAT_Q);
    assign do_exe_q = cmd_go && (op == rsch_pkg::OP_EXEC_ERR_Q);
    assign do_qry_q = cmd_go && (op == rsch_pkg::OP_QUERY_ERR_Q);
    // the wait opcode is known but has no decode of its own
    assign cmd_err = cmd_go && ((op == 5'h00) || (op > rsch_pkg::OP_LAST));
    assign is_query = cmd_go && ((op == rsch_pkg::OP_EVENT_EN_Q) ||
                      (op == rsch_pkg::OP_EVENT_STAT_Q) ||
                      (op == rsch_pkg::OP_INDIV_STAT_Q) ||
                      (op == rsch_pkg::OP_OPER_COMPLETE_Q) ||
                      (op == rsch_pkg::OP_POLL_EN_Q) ||
                      (op == rsch_pkg::OP_SRQ_EN_Q) ||
                      (op == rsch_pkg::OP_STATUS_BYTE_Q) ||
                      (op == rsch_pkg::OP_EXEC_ERR_Q) ||
                      (op == rsch_pkg::OP_QUERY_ERR_Q));
    assign store_ok = (arg >= 8'(rsch_pkg::STORE_MIN)) &&
                      (arg <= 8'(rsch_pkg::STORE_MAX));
    assign bad_store = do_save && !store_ok;

    // status byte and summaries
    logic esb, mav, mss, ist;
    logic [7:0] stb_low, stb;
    assign esb = |(esr_q & ese_q);
    assign mav = resp_valid_q;
    assign stb_low = {2'b00, esb, mav, 4'h0};
    assign mss = |(stb_low & sre_q);
    assign stb = stb_low | (8'(mss) << rsch_pkg::STB_MSS);
    assign ist = ist_local;

    // query answers, loaded at once so nothing is ever pending
    assign resp_d = !is_query ? resp_q :
        (op == rsch_pkg::OP_EVENT_EN_Q) ? ese_q :
        (op == rsch_pkg::OP_EVENT_STAT_Q) ? esr_q :
        (op == rsch_pkg::OP_INDIV_STAT_Q) ? {7'h00, ist} :
        (op == rsch_pkg::OP_OPER_COMPLETE_Q) ? rsch_pkg::OPC_ANSWER :
        (op == rsch_pkg::OP_POLL_EN_Q) ? pre_q :
        (op == rsch_pkg::OP_SRQ_EN_Q) ? sre_q :
        (op == rsch_pkg::OP_STATUS_BYTE_Q) ? stb :
        (op == rsch_pkg::OP_EXEC_ERR_Q) ? exe_q : qry_q;

    logic resp_read;
    assign resp_read = rd_acc && (avs_address == rsch_pkg::OFF_RESP);
    assign resp_valid_d = is_query | (resp_valid_q & ~resp_read);

    // learn stream
    logic learn_read, learn_end;
    assign learn_read = rd_acc && (avs_address == rsch_pkg::OFF_LEARN);
    assign learn_end = (learn_ptr_q == rsch_pkg::CHAR_W'(rsch_pkg::LEARN_CHARS));
    assign learn_ptr_d = do_learn ? '0 :
                         !learn_read ? learn_ptr_q :
                         learn_end ? '0 : learn_ptr_q + 1'b1;

    // install stream
    logic inst_char, inst_room, inst_wr, bad_char, is_term;
    logic [3:0] hex_nib;
    logic hex_ok;
    logic [7:0] learn_char, nib_char, mem_rd_data;
    assign inst_char = wr_acc && (avs_address == rsch_pkg::OFF_INSTALL);
    assign is_term = (avs_writedata[7:0] == rsch_pkg::TERM_CHAR);
    assign inst_room = (inst_ptr_q < rsch_pkg::CHAR_W'(rsch_pkg::LEARN_CHARS));
    // terminator ends the block quietly; anything else bad is an error
    assign bad_char = inst_char && !is_term && (!hex_ok || !inst_room);
    assign inst_wr = inst_char && hex_ok && inst_room && inst_ptr_q[0];
    assign inst_ptr_d = do_inst ? '0 :
                        (inst_char && hex_ok && inst_room) ?
                        inst_ptr_q + 1'b1 : inst_ptr_q;

    rsch_hex u_hex (
        .nibble_in(learn_ptr_q[0] ? mem_rd_data[3:0] : mem_rd_data[7:4]),
        .char_out(nib_char),
        .char_in(avs_writedata[7:0]),
        .nibble_out(hex_nib),
        .nibble_ok(hex_ok)
    );
    assign learn_char = learn_end ? rsch_pkg::TERM_CHAR : nib_char;

    // setup window and save copy
    logic setup_wr, save_wr, save_done, save_start;
    logic [rsch_pkg::MEM_AW-1:0] mem_wr_addr, mem_rd_addr;
    logic [7:0] mem_wr_data;
    assign setup_wr = wr_acc && (avs_address == rsch_pkg::OFF_SETUP_DATA);
    assign save_start = do_save && store_ok;
    assign save_wr = (state_q == rsch_pkg::ST_SAVE) && (save_cnt_q != '0);
    assign save_done = (state_q == rsch_pkg::ST_SAVE) &&
                       (save_cnt_q == rsch_pkg::SETUP_AW'(rsch_pkg::SETUP_BYTES));
    // write address lags the read by one cycle of the registered port
    assign mem_wr_addr = save_wr ? rsch_pkg::store_base(save_dst_q) +
                         rsch_pkg::MEM_AW'(save_cnt_q - 1'b1) :
                         inst_wr ? rsch_pkg::MEM_AW'(inst_ptr_q >> 1) :
                         rsch_pkg::MEM_AW'(setup_addr_q);
    assign mem_wr_data = save_wr ? mem_rd_data :
                         inst_wr ? {inst_hi_q, hex_nib} : avs_writedata[7:0];
    assign mem_rd_addr = (state_q == rsch_pkg::ST_SAVE) ?
                         rsch_pkg::MEM_AW'(save_cnt_q) :
                         (avs_address == rsch_pkg::OFF_LEARN) ?
                         rsch_pkg::MEM_AW'(learn_ptr_q >> 1) :
                         rsch_pkg::MEM_AW'(setup_addr_q);

    // learn only reads memory, it never writes a setting
    rsch_setup_mem u_mem (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_en(save_wr | inst_wr | setup_wr),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // error numbers; a new error beats a clear in the same cycle
    logic exe_set, qry_set, exe_clr, qry_clr, esr_clr;
    logic [7:0] exe_code, esr_set;
    assign exe_set = exe_err_valid | bad_store | bad_char;
    assign exe_code = exe_err_valid ? exe_err_code :
                      bad_store ? rsch_pkg::EXE_ERR_STORE : rsch_pkg::EXE_ERR_BLOCK;
    assign exe_clr = do_cls | do_exe_q;
    assign exe_d = exe_set ? exe_code : exe_clr ? 8'h00 : exe_q;
    assign qry_set = is_query && resp_valid_q;
    assign qry_clr = do_cls | do_qry_q;
    assign qry_d = qry_set ? rsch_pkg::QRY_ERR_UNREAD :
                   qry_clr ? 8'h00 : qry_q;
    assign esr_set = (8'(do_opc) << rsch_pkg::ESR_OPC) |
                     (8'(qry_set) << rsch_pkg::ESR_QYE) |
                     (8'(exe_set) << rsch_pkg::ESR_EXE) |
                     (8'(cmd_err) << rsch_pkg::ESR_CME);
    assign esr_clr = do_cls | do_esr_q;
    assign esr_d = (esr_clr ? 8'h00 : esr_q) | esr_set;
    assign ese_d = do_ese ? arg : ese_q;
    assign pre_d = do_pre ? arg : pre_q;
    assign sre_d = do_sre ? arg : sre_q;

    // interrupt status, cleared by reading it
    logic irq_read;
    logic [rsch_pkg::IRQ_W-1:0] irq_set;
    assign irq_read = rd_acc && (avs_address == rsch_pkg::OFF_IRQ_STATUS);
    assign irq_set = (rsch_pkg::IRQ_W'(is_query) << rsch_pkg::IRQ_RESP) |
        (rsch_pkg::IRQ_W'(save_done | (cmd_go & ~save_start))
            << rsch_pkg::IRQ_DONE) |
        (rsch_pkg::IRQ_W'(exe_set | qry_set | cmd_err) << rsch_pkg::IRQ_ERR);
    assign irq_stat_d = (irq_read ? '0 : irq_stat_q) | irq_set;

    // register read mux
    assign reg_rdata =
        (avs_address == rsch_pkg::OFF_RESP) ?
            32'({resp_valid_q, resp_q}) :
        (avs_address == rsch_pkg::OFF_IRQ_STATUS) ? 32'(irq_stat_q) :
        (avs_address == rsch_pkg::OFF_IRQ_MASK) ? 32'(irq_mask_q) :
        (avs_address == rsch_pkg::OFF_SETUP_ADDR) ? 32'(setup_addr_q) :
        (avs_address == rsch_pkg::OFF_STATUS) ?
            32'({esr_q, stb}) : 32'h0000_0000;
    assign mem_rdata = (avs_address == rsch_pkg::OFF_LEARN) ?
                       32'(learn_char) : 32'(mem_rd_data);
    assign rdata_d = (state_q == rsch_pkg::ST_IDLE) ? reg_rdata :
                     (state_q == rsch_pkg::ST_LWAIT) ? mem_rdata : rdata_q;

    // access sequencing; a save holds off every access until done
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rsch_pkg::ST_IDLE: begin
                if (req) begin
                    state_d = mem_read ? rsch_pkg::ST_LWAIT : rsch_pkg::ST_ACK;
                end
            end
            rsch_pkg::ST_LWAIT: begin
                state_d = rsch_pkg::ST_ACK;
            end
            rsch_pkg::ST_ACK: begin
                state_d = save_start ? rsch_pkg::ST_SAVE : rsch_pkg::ST_IDLE;
            end
            rsch_pkg::ST_SAVE: begin
                if (save_done) begin
                    state_d = rsch_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = rsch_pkg::ST_IDLE;
            end
        endcase
    end

    assign avs_waitrequest = !ack;
    assign avs_readdata = rdata_q;
    assign irq = irq_q;
    assign srq = srq_q;
    assign status_byte = stb_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= rsch_pkg::ST_IDLE;
            {ese_q, esr_q, pre_q, sre_q} <= 32'h0000_0000;
            {exe_q, qry_q, resp_q} <= 24'h00_0000;
            resp_valid_q <= 1'b0;
            irq_stat_q <= '0;
            learn_ptr_q <= '0;
            inst_ptr_q <= '0;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            {ese_q, esr_q, pre_q, sre_q} <= {ese_d, esr_d, pre_d, sre_d};
            {exe_q, qry_q, resp_q} <= {exe_d, qry_d, resp_d};
            resp_valid_q <= resp_valid_d;
            irq_stat_q <= irq_stat_d;
            learn_ptr_q <= learn_ptr_d;
            inst_ptr_q <= inst_ptr_d;
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_mask_q <= '0;
            setup_addr_q <= '0;
            inst_hi_q <= 4'h0;
            save_cnt_q <= '0;
            save_dst_q <= 4'h0;
        end else begin
            if (wr_acc && (avs_address == rsch_pkg::OFF_IRQ_MASK)) begin
                irq_mask_q <= avs_writedata[rsch_pkg::IRQ_W-1:0];
            end
            // addresses past the working setup are ignored
            if (wr_acc && (avs_address == rsch_pkg::OFF_SETUP_ADDR) &&
                (avs_writedata < 32'(rsch_pkg::SETUP_BYTES))) begin
                setup_addr_q <= avs_writedata[rsch_pkg::SETUP_AW-1:0];
            end
            if (inst_char && hex_ok && !inst_ptr_q[0]) begin
                inst_hi_q <= hex_nib;
            end
            if (save_start) begin
                save_dst_q <= arg[3:0];
            end
            save_cnt_q <= (state_q == rsch_pkg::ST_SAVE) ?
                          save_cnt_q + 1'b1 : '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
            srq_q <= 1'b0;
            stb_q <= 8'h00;
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_q);
            srq_q <= mss;
            stb_q <= stb;
        end
    end
endmodule // rsch_top

// >>> test/rsch_chk_sva.sv
/*
 rsch_chk: port-level timing checks of the command handler.
 Assumes: bound to rsch_top; one clock, byteenable always all ones.
*/
`timescale 1ns/1ns
module rsch_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic exe_err_valid,
    input wire logic irq,
    input wire logic srq,
    input wire logic [7:0] status_byte
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic ack = !avs_waitrequest;
    wire logic cmd_acc = ack && avs_write && avs_address == rsch_pkg::OFF_CMD;
    sequence s_cmd(logic [4:0] op);
        cmd_acc && avs_writedata[4:0] == op;
    endsequence
    a_ack_one_cycle: assert property (ack |=> !ack)
        else $error("waitrequest low for more than one cycle");
    a_srq_follows_stb: assert property (srq == status_byte[6])
        else $error("srq differs from status byte bit 6");
    a_stb_spare_zero: assert property (status_byte[3:0] == 4'h0 &&
        !status_byte[7]) else $error("unused status byte bit set");
    a_cmd_gets_ack: assert property ($rose(avs_write) &&
        avs_address == rsch_pkg::OFF_CMD |-> ##[1:430] ack)
        else $error("command write never acknowledged");
    a_query_sets_mav: assert property (
        s_cmd(rsch_pkg::OP_OPER_COMPLETE_Q) |-> ##2 status_byte[4])
        else $error("answer not flagged after query");
    a_clear_drops_esb: assert property (
        s_cmd(rsch_pkg::OP_CLEAR_STATUS) ##0 !exe_err_valid
        |-> ##2 !status_byte[5]) else $error("summary kept after clear");
    a_resp_read_clr: assert property (ack && avs_read &&
        avs_address == rsch_pkg::OFF_RESP |-> ##2 !status_byte[4])
        else $error("answer flag kept after read");
    a_irq_read_clr: assert property (ack && avs_read && !exe_err_valid &&
        avs_address == rsch_pkg::OFF_IRQ_STATUS |=> !irq)
        else $error("irq kept after status read");
    a_save_busy: assert property (s_cmd(rsch_pkg::OP_SETUP_SAVE)
        ##0 avs_writedata[15:8] inside {[8'h01:8'h09]}
        |=> avs_waitrequest [*8]) else $error("save copy not stalling");
endmodule // rsch_chk
bind rsch_top rsch_chk rsch_chk_inst (.ref_clk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
    .exe_err_valid, .irq, .srq, .status_byte);

// >>> test/rsch_ctrl_model.sv
/*
 rsch_ctrl_model: remote controller issuing register accesses.
 Assumes: drives the avalon slave of rsch_top on ref_clk.
*/
`timescale 1ns/1ns
module rsch_ctrl_model (
    input wire logic ref_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // waitrequest and readdata are taken at the rising edge, pre-update
    task automatic access(input logic wr, input logic [5:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // stale data is inverted so a late sampler cannot pass by luck
        avs_writedata <= ~d;
    endtask
endmodule // rsch_ctrl_model

// >>> test/tb.sv
/*
 tb: command and register access sequences with expected values.
 Assumes: rsch_top and the controller model share one 250 MHz clock.
*/
`timescale 1ns/1ns
module tb;
    logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
    logic exe_err_valid, ist_local;
    logic [7:0] exe_err_code, status_byte;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, v;
    logic [7:0] blk [843];
    int failures, num_checks;
    rsch_top rsch_top_inst (.ref_clk, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(rsch_pkg::BE_ALL),
        .avs_readdata, .avs_waitrequest, .exe_err_valid, .exe_err_code,
        .ist_local, .irq, .srq(), .status_byte);
    rsch_ctrl_model rsch_ctrl_model_inst (.ref_clk, .avs_waitrequest,
        .avs_readdata, .avs_address, .avs_read, .avs_write, .avs_writedata);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        rsch_ctrl_model_inst.access(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [5:0] a);
        rsch_ctrl_model_inst.access(1'b0, a, 32'h0, v);
    endtask
    task automatic cmd(input logic [4:0] op, input logic [7:0] arg);
        wr(rsch_pkg::OFF_CMD, {16'h0, arg, 3'h0, op});
    endtask
    task automatic qry(input logic [4:0] op, input logic [7:0] e);
        cmd(op, 8'h00);
        rd(rsch_pkg::OFF_RESP);
        chk("answer", v[8:0], {1'b1, e});
    endtask
    // an execution error pulse, then a query error by an unread answer
    task automatic errs();
        exe_err_code <= 8'h37;
        exe_err_valid <= 1'b1;
        @(posedge ref_clk);
        exe_err_valid <= 1'b0;
        cmd(rsch_pkg::OP_EVENT_EN_Q, 8'h00);
        qry(rsch_pkg::OP_EVENT_EN_Q, 8'h21);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        sys_rst = 1'b1;
        exe_err_valid = 1'b0;
        exe_err_code = 8'h00;
        ist_local = 1'b0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(rsch_pkg::OFF_IRQ_MASK);
        chk("mask reset", v, 32'h0);
        wr(rsch_pkg::OFF_IRQ_MASK, 32'h7);
        rd(6'h3c);
        chk("unmapped", v, 32'h0);
        cmd(rsch_pkg::OP_EVENT_EN_SET, 8'h21);
        qry(rsch_pkg::OP_EVENT_EN_Q, 8'h21);
        cmd(rsch_pkg::OP_POLL_EN_SET, 8'h5a);
        qry(rsch_pkg::OP_POLL_EN_Q, 8'h5a);
        cmd(rsch_pkg::OP_SRQ_EN_SET, 8'h20);
        qry(rsch_pkg::OP_SRQ_EN_Q, 8'h20);
        cmd(rsch_pkg::OP_OPER_COMPLETE, 8'h00);
        cmd(rsch_pkg::OP_WAIT, 8'h00);
        rd(rsch_pkg::OFF_STATUS);
        chk("status", v, 32'h0160);
        chk("irq up", irq, 1'b1);
        rd(rsch_pkg::OFF_IRQ_STATUS);
        chk("irq status", v, 32'h3);
        @(negedge ref_clk);
        chk("irq down", irq, 1'b0);
        qry(rsch_pkg::OP_OPER_COMPLETE_Q, 8'h01);
        qry(rsch_pkg::OP_STATUS_BYTE_Q, 8'h60);
        qry(rsch_pkg::OP_EVENT_STAT_Q, 8'h01);
        qry(rsch_pkg::OP_EVENT_STAT_Q, 8'h00);
        for (int i = 0; i < 2; i++) begin
            ist_local <= i[0];
            qry(rsch_pkg::OP_INDIV_STAT_Q, 8'(i));
        end
        errs();
        qry(rsch_pkg::OP_EXEC_ERR_Q, 8'h37);
        qry(rsch_pkg::OP_EXEC_ERR_Q, 8'h00);
        qry(rsch_pkg::OP_QUERY_ERR_Q, 8'h01);
        qry(rsch_pkg::OP_QUERY_ERR_Q, 8'h00);
        errs();
        cmd(rsch_pkg::OP_OPER_COMPLETE, 8'h00);
        cmd(rsch_pkg::OP_CLEAR_STATUS, 8'h00);
        qry(rsch_pkg::OP_EXEC_ERR_Q, 8'h00);
        qry(rsch_pkg::OP_QUERY_ERR_Q, 8'h00);
        qry(rsch_pkg::OP_EVENT_STAT_Q, 8'h00);
        for (int k = 0; k < 2; k++) begin
            cmd(rsch_pkg::OP_SETUP_SAVE, k == 0 ? 8'h00 : 8'h0a);
            qry(rsch_pkg::OP_EXEC_ERR_Q, 8'h01);
        end
        cmd(rsch_pkg::OP_SETUP_SAVE, 8'h09);
        qry(rsch_pkg::OP_EXEC_ERR_Q, 8'h00);
        // fill every byte so learn and install see no unknowns; ends at 0
        for (int i = 420; i >= 0; i--) begin
            wr(rsch_pkg::OFF_SETUP_ADDR, 32'(i));
            wr(rsch_pkg::OFF_SETUP_DATA, 32'(i) ^ 32'ha5);
        end
        cmd(rsch_pkg::OP_LEARN_Q, 8'h00);
        for (int i = 0; i < 843; i++) begin
            rd(rsch_pkg::OFF_LEARN);
            blk[i] = v[7:0];
        end
        chk("learn", {blk[0], blk[1], blk[842]}, 24'h41350a);
        rd(rsch_pkg::OFF_SETUP_DATA);
        chk("kept", v, 32'ha5);
        wr(rsch_pkg::OFF_SETUP_DATA, 32'h0);
        cmd(rsch_pkg::OP_INSTALL, 8'h00);
        foreach (blk[i]) wr(rsch_pkg::OFF_INSTALL, {24'h0, blk[i]});
        rd(rsch_pkg::OFF_SETUP_DATA);
        chk("installed", v, 32'ha5);
        complete_run();
    end
endmodule // tb
